/* File: inc/cpu_mode_exception_pkg.sv */
// Constants, types and state layout of the mode and exception control block
`default_nettype none

package cpu_mode_exception_pkg;

   // ***************************************************************
   // Status word layout
   // ***************************************************************
   localparam int WORD_W = 32;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 4;
   localparam int BIT_T = 5;
   localparam int BIT_F = 6;
   localparam int BIT_I = 7;
   localparam int FLAGS_LSB = 28;
   localparam int FLAGS_MSB = 31;
   localparam logic [31:0] STATUS_KEEP_MASK = 32'hF00000FF;
   localparam logic [31:0] STATUS_RESET = 32'h000000D3;

   // ***************************************************************
   // Mode codes
   // ***************************************************************
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_UND = 5'h1B;
   localparam logic [4:0] MODE_SYS = 5'h1F;

   // ***************************************************************
   // Vectors and return offsets
   // ***************************************************************
   localparam logic [31:0] VEC_RESET = 32'h00000000;
   localparam logic [31:0] VEC_UNDEF = 32'h00000004;
   localparam logic [31:0] VEC_TRAP = 32'h00000008;
   localparam logic [31:0] VEC_IRQ = 32'h00000018;
   localparam logic [31:0] VEC_FIQ = 32'h0000001C;
   localparam logic [31:0] RET_OFS_WIDE = 32'h00000004;
   localparam logic [31:0] RET_OFS_COMPACT = 32'h00000002;

   // ***************************************************************
   // Register file geometry
   // ***************************************************************
   localparam int NUM_PHYS = 28;
   localparam logic [4:0] PHYS_FIQ_BASE = 5'h0F;
   localparam logic [4:0] PHYS_SVC_BASE = 5'h16;
   localparam logic [4:0] PHYS_IRQ_BASE = 5'h18;
   localparam logic [4:0] PHYS_UND_BASE = 5'h1A;
   localparam logic [3:0] IDX_FIQ_FIRST = 4'h8;
   localparam logic [3:0] IDX_SP = 4'hD;
   localparam logic [3:0] IDX_LR = 4'hE;
   localparam logic [1:0] SAVED_FIQ = 2'h0;
   localparam logic [1:0] SAVED_IRQ = 2'h1;
   localparam logic [1:0] SAVED_SVC = 2'h2;
   localparam logic [1:0] SAVED_UND = 2'h3;

   // ***************************************************************
   // Exception causes
   // ***************************************************************
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_RESET = 3'h1;
   localparam logic [2:0] CAUSE_UNDEF = 3'h2;
   localparam logic [2:0] CAUSE_TRAP = 3'h3;
   localparam logic [2:0] CAUSE_IRQ = 3'h4;
   localparam logic [2:0] CAUSE_FIQ = 3'h5;

   // ***************************************************************
   // APB register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] OFS_CURRENT = 8'h00;
   localparam logic [7:0] OFS_SAVED = 8'h04;
   localparam logic [7:0] OFS_ENTRY_INFO = 8'h08;
   localparam logic [7:0] OFS_LAST_LINK = 8'h0C;
   localparam int INFO_LOCKED_BIT = 8;
   localparam int INFO_BUSY_BIT = 9;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [4:0] {
      ST_RESET_SAVE = 5'b00001,
      ST_RUN = 5'b00010,
      ST_SAVE = 5'b00100,
      ST_VECTOR = 5'b01000,
      ST_LOCKED = 5'b10000
   } state_e;

   typedef struct packed {
      logic boundary;
      logic [31:0] pc;
      logic sw_trap;
      logic undef;
      logic branch_with_link;
      logic ret;
      logic status_wr;
      logic [31:0] status_data;
   } pipe_event_s;

   typedef struct packed {
      logic we;
      logic [3:0] idx;
      logic [31:0] data;
   } reg_write_s;

   typedef struct packed {
      state_e state;
      logic [31:0] current_status_word;
      logic [3:0][31:0] saved;
      logic [NUM_PHYS-1:0][31:0] regs;
      logic [4:0] target_mode;
      logic [2:0] cause;
      logic [31:0] vec;
      logic [31:0] link;
      logic vec_valid;
      logic [31:0] prdata;
      logic pslverr;
   } core_state_s;

endpackage : cpu_mode_exception_pkg

`default_nettype wire

/* File: src/cpu_mode_exception_control.sv */
// Mode, banked register and exception entry control of the processor core
//
// Local design decisions: the address map and the APB slave port.
`default_nettype none

module cpu_mode_exception_control
   import cpu_mode_exception_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt controller requests
   input wire logic fiq_req,
   input wire logic irq_req,
   // Decode pipeline
   input wire pipe_event_s pipe_event,
   input wire reg_write_s reg_write,
   input wire logic [3:0] reg_read_idx,
   output logic [31:0] reg_read_data,
   output logic busy,
   output logic vector_valid,
   output logic [31:0] vector_addr,
   output logic [31:0] current_status_word,
   output logic compact_state
);

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   if (ADDR_W < 8)
   begin : g_bad_addr
      $error("ADDR_W must cover the register map");
   end

   // ***************************************************************
   // Helper functions
   // ***************************************************************
   // Valid mode codes only; anything else locks the core
   function automatic logic mode_valid(input logic [4:0] m);
      return (m == MODE_USR) || (m == MODE_FIQ) || (m == MODE_IRQ) ||
             (m == MODE_SVC) || (m == MODE_UND) || (m == MODE_SYS);
   endfunction : mode_valid

   // Logical register number to physical slot, per mode
   function automatic logic [4:0] phys_idx(input logic [4:0] m, input logic [3:0] idx);
      logic [4:0] p;
      p = {1'b0, idx};
      if ((m == MODE_FIQ) && (idx >= IDX_FIQ_FIRST) && (idx <= IDX_LR))
      begin
         p = PHYS_FIQ_BASE + {1'b0, idx - IDX_FIQ_FIRST};
      end
      else if ((idx == IDX_SP) || (idx == IDX_LR))
      begin
         // User and system modes fall through to the base set
         unique case (m)
            MODE_SVC: p = PHYS_SVC_BASE + {4'h0, idx[0] ^ 1'b1};
            MODE_IRQ: p = PHYS_IRQ_BASE + {4'h0, idx[0] ^ 1'b1};
            MODE_UND: p = PHYS_UND_BASE + {4'h0, idx[0] ^ 1'b1};
            default: p = {1'b0, idx};
         endcase
      end
      return p;
   endfunction : phys_idx

   // Saved status slot of a mode; user and system have none
   function automatic logic has_saved(input logic [4:0] m);
      return (m == MODE_FIQ) || (m == MODE_IRQ) || (m == MODE_SVC) || (m == MODE_UND);
   endfunction : has_saved

   function automatic logic [1:0] saved_idx(input logic [4:0] m);
      logic [1:0] s;
      unique case (m)
         MODE_FIQ: s = SAVED_FIQ;
         MODE_IRQ: s = SAVED_IRQ;
         MODE_UND: s = SAVED_UND;
         default: s = SAVED_SVC;
      endcase
      return s;
   endfunction : saved_idx

   // Software status write: flags always, mode, I and F only when privileged
   function automatic logic [31:0] status_write(input logic [31:0] cur,
                                                input logic [31:0] data);
      logic [31:0] res;
      res = cur;
      res[FLAGS_MSB:FLAGS_LSB] = data[FLAGS_MSB:FLAGS_LSB];
      if (cur[MODE_MSB:MODE_LSB] != MODE_USR)
      begin
         res[MODE_MSB:MODE_LSB] = data[MODE_MSB:MODE_LSB];
         res[BIT_I] = data[BIT_I];
         res[BIT_F] = data[BIT_F];
      end
      return res & STATUS_KEEP_MASK;
   endfunction : status_write

   // ***************************************************************
   // State
   // ***************************************************************
   core_state_s r;
   core_state_s next_r;
   logic [4:0] cur_mode;
   logic apb_setup;
   logic apb_write;
   logic [7:0] apb_ofs;
   logic fiq_take;
   logic irq_take;

   assign cur_mode = r.current_status_word[MODE_MSB:MODE_LSB];
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite;
   assign apb_ofs = paddr[7:0];
   // Masked requests are not seen at all
   assign fiq_take = fiq_req && !r.current_status_word[BIT_F];
   assign irq_take = irq_req && !r.current_status_word[BIT_I];

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb
   begin
      logic [31:0] cur;
      logic [31:0] ofs;
      cur = r.current_status_word;
      ofs = RET_OFS_WIDE;
      next_r = r;
      next_r.vec_valid = 1'b0;

      // APB read data prepared in the setup cycle, zero wait states
      if (apb_setup)
      begin
         next_r.pslverr = 1'b0;
         next_r.prdata = '0;
         unique case (apb_ofs)
            OFS_CURRENT: next_r.prdata = cur;
            OFS_SAVED: next_r.prdata = has_saved(cur_mode) ? r.saved[saved_idx(cur_mode)] : '0;
            OFS_ENTRY_INFO:
            begin
               next_r.prdata[2:0] = r.cause;
               next_r.prdata[INFO_LOCKED_BIT] = (r.state == ST_LOCKED);
               next_r.prdata[INFO_BUSY_BIT] = (r.state != ST_RUN);
            end
            OFS_LAST_LINK: next_r.prdata = r.link;
            default: next_r.pslverr = 1'b1;
         endcase
      end

      unique case (r.state)
         // Reset save: supervisor link and saved status take pc and status
         ST_RESET_SAVE:
         begin
            next_r.regs[phys_idx(MODE_SVC, IDX_LR)] = pipe_event.pc;
            next_r.saved[SAVED_SVC] = cur;
            next_r.target_mode = MODE_SVC;
            next_r.vec = VEC_RESET;
            next_r.cause = CAUSE_RESET;
            next_r.state = ST_VECTOR;
         end

         ST_RUN:
         begin
            if (!mode_valid(cur_mode))
            begin
               next_r.state = ST_LOCKED;
            end
            else if (pipe_event.boundary &&
                     (fiq_take || irq_take || pipe_event.undef || pipe_event.sw_trap))
            begin
               // Sampled only at a boundary; fast beats normal beats traps
               if (fiq_take)
               begin
                  next_r.target_mode = MODE_FIQ;
                  next_r.vec = VEC_FIQ;
                  next_r.cause = CAUSE_FIQ;
               end
               else if (irq_take)
               begin
                  next_r.target_mode = MODE_IRQ;
                  next_r.vec = VEC_IRQ;
                  next_r.cause = CAUSE_IRQ;
               end
               else if (pipe_event.undef)
               begin
                  next_r.target_mode = MODE_UND;
                  next_r.vec = VEC_UNDEF;
                  next_r.cause = CAUSE_UNDEF;
               end
               else
               begin
                  next_r.target_mode = MODE_SVC;
                  next_r.vec = VEC_TRAP;
                  next_r.cause = CAUSE_TRAP;
               end
               // Interrupts return past the unexecuted instruction, both states
               if (!fiq_take && !irq_take && cur[BIT_T])
               begin
                  ofs = RET_OFS_COMPACT;
               end
               next_r.link = pipe_event.pc + ofs;
               next_r.state = ST_SAVE;
            end
            else
            begin
               // Ordinary register file writes from the pipeline
               if (reg_write.we && (reg_write.idx != 4'hF))
               begin
                  next_r.regs[phys_idx(cur_mode, reg_write.idx)] = reg_write.data;
               end
               if (pipe_event.boundary && pipe_event.branch_with_link)
               begin
                  ofs = cur[BIT_T] ? RET_OFS_COMPACT : RET_OFS_WIDE;
                  next_r.regs[phys_idx(cur_mode, IDX_LR)] = pipe_event.pc + ofs;
               end
               // Return restores the whole word, state select included
               if (pipe_event.boundary && pipe_event.ret && has_saved(cur_mode))
               begin
                  next_r.current_status_word =
                     r.saved[saved_idx(cur_mode)] & STATUS_KEEP_MASK;
               end
               else if (pipe_event.boundary && pipe_event.status_wr)
               begin
                  next_r.current_status_word = status_write(cur, pipe_event.status_data);
               end
               else if (apb_write && (apb_ofs == OFS_CURRENT))
               begin
                  // Debug path obeys the same privilege check as software
                  next_r.current_status_word = status_write(cur, pwdata);
               end
            end
         end

         // Save link and status into the target bank before the mode changes
         ST_SAVE:
         begin
            next_r.regs[phys_idx(r.target_mode, IDX_LR)] = r.link;
            next_r.saved[saved_idx(r.target_mode)] = cur;
            next_r.state = ST_VECTOR;
         end

         // Force mode, I mask (F too on fast or reset entry) and state select, then hand out the vector
         ST_VECTOR:
         begin
            next_r.current_status_word[MODE_MSB:MODE_LSB] = r.target_mode;
            next_r.current_status_word[BIT_T] = 1'b0;
            next_r.current_status_word[BIT_I] = 1'b1;
            if ((r.cause == CAUSE_FIQ) || (r.cause == CAUSE_RESET))
            begin
               next_r.current_status_word[BIT_F] = 1'b1;
            end
            next_r.vec_valid = 1'b1;
            next_r.state = ST_RUN;
         end

         // Unrecoverable: only reset leaves here
         ST_LOCKED:
         begin
            next_r.state = ST_LOCKED;
         end

         default:
         begin
            next_r.state = ST_LOCKED;
         end
      endcase
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   // Reset lands in supervisor, masks set, full-width; the save follows
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.state <= ST_RESET_SAVE;
         r.current_status_word <= STATUS_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Busy stalls the pipeline until entry is complete
   assign busy = (r.state != ST_RUN);
   assign vector_valid = r.vec_valid;
   assign vector_addr = r.vec;
   assign current_status_word = r.current_status_word;
   assign compact_state = r.current_status_word[BIT_T];
   assign pready = 1'b1;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr && psel && penable;
   // Index 15 is the program counter, owned by the fetch logic
   assign reg_read_data = (reg_read_idx == 4'hF) ? '0 : r.regs[phys_idx(cur_mode, reg_read_idx)];

endmodule : cpu_mode_exception_control

`default_nettype wire

/* File: verif/cpu_mode_exception_sva.sv */
// Checker of exception entry and status rules at the block's ports
`default_nettype none
module cpu_mode_exception_sva
   import cpu_mode_exception_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic fiq_req,
   input wire logic irq_req,
   input wire pipe_event_s pipe_event,
   input wire logic busy,
   input wire logic vector_valid,
   input wire logic [31:0] vector_addr,
   input wire logic [31:0] current_status_word,
   input wire logic compact_state
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // Entry decode
   // ********************
   // Causes ranked as the core must rank them
   logic fq, iq, ud, sw, tk;
   assign fq = fiq_req && !current_status_word[BIT_F];
   assign iq = irq_req && !current_status_word[BIT_I] && !fq;
   assign ud = pipe_event.undef && !fq && !iq;
   assign sw = pipe_event.sw_trap && !pipe_event.undef && !fq && !iq;
   assign tk = !busy && pipe_event.boundary;

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Two busy cycles, then the vector pulse
   sequence s_entry;
      busy ##1 busy ##1 (vector_valid && !busy);
   endsequence
   property p_vec(c, a, m);
      tk && c |=> s_entry ##0 (vector_addr == a && current_status_word[4:0] == m);
   endproperty

   AST_VEC_FIQ: assert property (p_vec(fq, VEC_FIQ, MODE_FIQ))
      else $error("fast entry wrong");
   AST_VEC_IRQ: assert property (p_vec(iq, VEC_IRQ, MODE_IRQ))
      else $error("normal entry wrong");
   AST_VEC_UNDEF: assert property (p_vec(ud, VEC_UNDEF, MODE_UND))
      else $error("undefined entry wrong");
   AST_VEC_TRAP: assert property (p_vec(sw, VEC_TRAP, MODE_SVC))
      else $error("trap entry wrong");
   AST_FIQ_MASKS: assert property (tk && fq |=> ##2 current_status_word[7:6] == 2'b11)
      else $error("fast entry masks wrong");
   AST_ENTRY_CTRL: assert property (vector_valid |-> current_status_word[BIT_I]
      && !current_status_word[BIT_T])
      else $error("entry control bits wrong");
   AST_MASKED: assert property (tk && !fq && !iq && !pipe_event.undef
      && !pipe_event.sw_trap && !pipe_event.status_wr |=> !busy)
      else $error("entry without cause");
   AST_RESERVED: assert property (current_status_word[27:8] == 20'h0)
      else $error("reserved status bits set");
   AST_RESET_CTRL: assert property (vector_valid && vector_addr == VEC_RESET
      |-> current_status_word[7:0] == 8'hD3)
      else $error("reset status wrong");
   AST_USER_WR: assert property (psel && penable && pwrite && !busy
      && paddr[7:0] == OFS_CURRENT && current_status_word[4:0] == MODE_USR
      && !pipe_event.boundary |=> $stable(current_status_word[7:0]))
      else $error("user changed control bits");
   AST_T_MIRROR: assert property (compact_state == current_status_word[BIT_T])
      else $error("state select mismatch");
endmodule : cpu_mode_exception_sva

bind cpu_mode_exception_control cpu_mode_exception_sva #(.ADDR_W(ADDR_W))
   cpu_mode_exception_sva_i (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .fiq_req(fiq_req), .irq_req(irq_req),
   .pipe_event(pipe_event), .busy(busy), .vector_valid(vector_valid),
   .vector_addr(vector_addr), .current_status_word(current_status_word),
   .compact_state(compact_state));
`default_nettype wire

/* File: verif/pipe_partner.sv */
// Model of the decode pipeline and the interrupt request lines
`default_nettype none
module pipe_partner
   import cpu_mode_exception_pkg::*;
(
   input wire logic busy,
   input wire logic go,
   input wire pipe_event_s ev,
   input wire logic fiq_in,
   input wire logic irq_in,
   output var pipe_event_s pipe_event,
   output logic fiq_req,
   output logic irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********************
   // Event issue
   // ********************
   // Boundaries held while busy; idle qualifiers scrambled, never a stale copy
   always_comb
   begin
      pipe_event = ~ev;
      pipe_event.boundary = 1'b0;
      if (go && !busy)
      begin
         pipe_event = ev;
         pipe_event.sw_trap = ev.sw_trap && !ev.undef;
      end
   end
   // Request levels pass straight through
   assign fiq_req = fiq_in;
   assign irq_req = irq_in;
endmodule : pipe_partner
`default_nettype wire

/* File: verif/cpu_mode_exception_control_bench.sv */
// Self-checking bench of the mode and exception control block
`default_nettype none
module cpu_mode_exception_control_bench
   import cpu_mode_exception_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic fiq_in = 1'b0;
   logic irq_in = 1'b0;
   logic go = 1'b0;
   pipe_event_s ev = '0;
   pipe_event_s pipe_event;
   reg_write_s reg_write = '0;
   logic [3:0] reg_read_idx = 4'h0;
   logic [31:0] prdata, reg_read_data, vector_addr, csw, rdata;
   logic pready, pslverr, fiq_req, irq_req, busy, vector_valid, compact_state, slverr;
   logic [63:0] exp_q[$];
   logic [63:0] e_note;
   integer errors = 0;
   integer checks = 0;
   integer cyc = 0;
   integer seed = 32'h6FF2FC15;

   // ********************
   // Harness
   // ********************
   // 200 MHz core clock
   always #2.5 clk_sys = ~clk_sys;

   cpu_mode_exception_control #(.ADDR_W(12)) cpu_mode_exception_control_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fiq_req(fiq_req), .irq_req(irq_req), .pipe_event(pipe_event), .reg_write(reg_write),
      .reg_read_idx(reg_read_idx), .reg_read_data(reg_read_data), .busy(busy),
      .vector_valid(vector_valid), .vector_addr(vector_addr), .current_status_word(csw),
      .compact_state(compact_state));

   pipe_partner pipe_partner_i (.busy(busy), .go(go), .ev(ev), .fiq_in(fiq_in),
      .irq_in(irq_in), .pipe_event(pipe_event), .fiq_req(fiq_req), .irq_req(irq_req));

   task automatic check(input logic [31:0] s, input logic [31:0] e, input string w);
      checks++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", w, e, s);
      end
   endtask : check

   task automatic conclude();
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // One APB transfer; an idle edge after it keeps drivers apart
   // Waits on pready alone; only the bench timeout ends a stuck transfer
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {4'h0, a};
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rdata, e, "prdata");
   endtask : rd

   task automatic wait_idle();
      do
         @(posedge clk_sys);
      while (busy !== 1'b0);
   endtask : wait_idle

   task automatic fire(input logic [31:0] pc, input logic t, input logic u, input logic r);
      ev <= '{1'b1, pc, t, u, 1'b0, r, 1'b0, 32'h0};
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
   endtask : fire

   task automatic regw(input logic [3:0] i, input logic [31:0] d);
      reg_write <= '{1'b1, i, d};
      @(posedge clk_sys);
      reg_write.we <= 1'b0;
   endtask : regw

   task automatic reg_rd(input logic [3:0] i, input logic [31:0] e);
      reg_read_idx <= i;
      @(posedge clk_sys);
      check(reg_read_data, e, "reg_read_data");
   endtask : reg_rd

   // Each vector pulse retires the oldest note; an unexpected pulse meets x
   always @(posedge clk_sys)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
      begin
         errors++;
         conclude();
      end
      if (rst_n === 1'b1 && vector_valid === 1'b1)
      begin
         e_note = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
         check(vector_addr, e_note[63:32], "vector_addr");
         check(csw, e_note[31:0], "status");
      end
   end

   // ********************
   // Scenarios
   // ********************
   initial
   begin
      logic [31:0] pc, st, cur, d, a;
      integer k;
      exp_q.push_back({VEC_RESET, STATUS_RESET});
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      wait_idle();
      rd(OFS_CURRENT, STATUS_RESET);
      // Privileged write drops to user mode with masks open
      d = $random(seed);
      d[7:0] = {3'b000, MODE_USR};
      apb(1'b1, OFS_CURRENT, d);
      st = d & STATUS_KEEP_MASK;
      rd(OFS_CURRENT, st);
      // User write may move flags only
      d = $random(seed);
      d[7:0] = 8'hD3;
      apb(1'b1, OFS_CURRENT, d);
      st[31:28] = d[31:28];
      rd(OFS_CURRENT, st);
      a = $random(seed);
      regw(IDX_FIQ_FIRST, a);
      // Normal interrupt taken from user mode
      pc = $random(seed) & 32'hFFFFFFFC;
      cur = {st[31:8], 3'b100, MODE_IRQ};
      exp_q.push_back({VEC_IRQ, cur});
      irq_in <= 1'b1;
      fire(pc, 1'b0, 1'b0, 1'b0);
      irq_in <= 1'b0;
      wait_idle();
      rd(OFS_SAVED, st);
      rd(OFS_LAST_LINK, pc + RET_OFS_WIDE);
      reg_rd(IDX_LR, pc + RET_OFS_WIDE);
      // Everything at once: fast wins and masks both
      st = cur;
      cur = {st[31:8], 3'b110, MODE_FIQ};
      exp_q.push_back({VEC_FIQ, cur});
      fiq_in <= 1'b1;
      irq_in <= 1'b1;
      fire(pc, 1'b1, 1'b1, 1'b0);
      wait_idle();
      regw(IDX_FIQ_FIRST, ~a);
      // Requests still high but masked in fast mode
      fire(pc, 1'b0, 1'b0, 1'b0);
      @(posedge clk_sys);
      check({31'h0, busy}, 32'h0, "busy");
      fiq_in <= 1'b0;
      irq_in <= 1'b0;
      // Return brings back the interrupted status and base r8
      fire(pc, 1'b0, 1'b0, 1'b1);
      wait_idle();
      rd(OFS_CURRENT, st);
      reg_rd(IDX_FIQ_FIRST, a);
      // Undefined trap, then software trap
      for (k = 0; k < 2; k++)
      begin
         pc = $random(seed) & 32'hFFFFFFFC;
         cur = {st[31:8], 1'b1, st[6], 1'b0, k == 0 ? MODE_UND : MODE_SVC};
         exp_q.push_back({k == 0 ? VEC_UNDEF : VEC_TRAP, cur});
         fire(pc, k == 1, k == 0, 1'b0);
         wait_idle();
         rd(OFS_LAST_LINK, pc + RET_OFS_WIDE);
         st = cur;
      end
      // Unmapped offset answers with an error and zero
      apb(1'b0, 8'h10, 32'h0);
      check(rdata, 32'h0, "prdata");
      check({31'h0, slverr}, 32'h1, "pslverr");
      // Invalid mode locks the core until reset
      apb(1'b1, OFS_CURRENT, {st[31:5], 5'h15});
      repeat (3) @(posedge clk_sys);
      check({31'h0, busy}, 32'h1, "busy");
      exp_q.push_back({VEC_RESET, STATUS_RESET});
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      wait_idle();
      rd(OFS_CURRENT, STATUS_RESET);
      check(32'(exp_q.size()), 32'h0, "pending");
      conclude();
   end
endmodule : cpu_mode_exception_control_bench
`default_nettype wire
